// File: rtl/dsb_fifo.sv
// Purpose: small first-in first-out buffer with valid and ready on both sides
// Assumes: width and depth set by the instance, depth a power of two
// Notes:   full and empty come straight from the occupancy count
`timescale 1ns/1ps
module dsb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  store [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [PW:0]   count_reg, count_next;
  logic          push, pop;

  // handshakes and pointer update, ready while a slot is free
  always_comb begin
    o_in_ready  = (count_reg < (PW+1)'(DEPTH));
    o_out_valid = (count_reg != '0);
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);
  end

  // registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      store[wr_ptr_reg] <= i_in_data;
    end
  end

  assign o_out_data = store[rd_ptr_reg];

endmodule : dsb_fifo

// File: rtl/dsb_pkg.sv
// Purpose: shared constants and carrier types for the burst-2 ddr sram port
// Assumes: narrow variant, 18-bit data bus, 21 address inputs
// Notes:   all pins are sampled by the reference clock after two flops
package dsb_pkg;

  // geometry of the narrow variant
  localparam int DATA_W     = 18;
  localparam int ADDR_W     = 21;
  localparam int LANE_W     = 9;
  localparam int LANES      = 2;
  localparam int ROW_W      = 20;
  localparam int BANKS      = 2;
  localparam int ROWS       = 1048576;
  localparam int FIFO_DEPTH = 4;

  // bit position of the burst counter within the address
  localparam int BURST_LSB_POS = 0;

  // values after reset
  localparam logic [DATA_W-1:0] RST_DQ     = 18'h00000;
  localparam logic [ADDR_W-1:0] RST_ADDR   = 21'h000000;
  localparam logic [1:0]        RST_PHASE  = 2'h0;
  localparam logic [3:0]        RST_CLKS   = 4'h0;

  // pin group sampled from the controller
  typedef struct packed {
    logic              k;
    logic              k_n;
    logic              c;
    logic              c_n;
    logic              single_clk;
    logic              cycle_define_n;
    logic              rw;
    logic [LANES-1:0]  byte_lane_mask_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } dsb_pin_type;

  // one write word on its way to the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  mask_n;
  } dsb_wr_word_type;

endpackage : dsb_pkg

// File: rtl/dsb_port.sv
// Purpose: pin-level burst-2 ddr sram device seen from the reference clock
// Assumes: all controller pins are slow against the 200 MHz reference clock
// Notes:   clock pins are sampled and their rising edges found in logic
//
// Function
// - write word sampled on rising edge of positive and negative input clock
// - read words driven on output clock edges, input clocks in single mode
// - data drivers released whenever no read is being driven
// - every access moves exactly two words
// - with cycle define low, direction high reads and low writes
// - deasserted active-low lane mask leaves that stored byte unchanged
// - lane 0 covers bits 8..0, lane 1 bits 17..9
// - lane masks sampled on the same edge as their data word
// - burst lsb loaded into a one-bit counter, advanced for second word
// - narrow variant uses 21 address inputs
// - storage is two equal arrays of 1M by 18
// - address ignored in cycles without cycle define
// - accesses start only on rising edge of positive input clock
`timescale 1ns/1ps
module dsb_port (
  input  wire logic                          I_REF_CLK,
  input  wire logic                          I_RST_N,
  input  wire logic                          I_K,
  input  wire logic                          I_K_N,
  input  wire logic                          I_C,
  input  wire logic                          I_C_N,
  input  wire logic                          I_SINGLE_CLK,
  input  wire logic                          I_CYCLE_DEFINE_N,
  input  wire logic                          I_RW,
  input  wire logic [dsb_pkg::LANES-1:0]     I_BYTE_LANE_MASK_N,
  input  wire logic [dsb_pkg::ADDR_W-1:0]    I_ADDR,
  input  wire logic [dsb_pkg::DATA_W-1:0]    I_DQ,
  output logic      [dsb_pkg::DATA_W-1:0]    O_DQ,
  output logic                               O_DQ_OE_N,
  output logic                               O_WRITE_READY
);

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and edge detection

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_FETCH0 = 6'h02,
    ST_FETCH1 = 6'h04,
    ST_WAIT   = 6'h08,
    ST_DRIVE0 = 6'h10,
    ST_DRIVE1 = 6'h20
  } dsb_state_type;

  dsb_pkg::dsb_pin_type     pin_raw, pin;
  dsb_pkg::dsb_wr_word_type push_word, drain_word;
  logic [3:0] clk_prev_reg, clk_prev_next;
  logic       k_rise, kn_rise, c_rise, cn_rise, out_rise, out_fall;

  // gather pins into one group
  assign pin_raw = '{k: I_K, k_n: I_K_N, c: I_C, c_n: I_C_N, single_clk: I_SINGLE_CLK,
                     cycle_define_n: I_CYCLE_DEFINE_N, rw: I_RW,
                     byte_lane_mask_n: I_BYTE_LANE_MASK_N, addr: I_ADDR, dq: I_DQ};

  dsb_sync #(
    .W ($bits(dsb_pkg::dsb_pin_type))
  ) u_sync (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_async (pin_raw),
    .o_sync  (pin)
  );

  // rising edges of the four sampled clocks
  always_comb begin
    clk_prev_next = {pin.k, pin.k_n, pin.c, pin.c_n};
    k_rise        = pin.k && !clk_prev_reg[3];
    kn_rise       = pin.k_n && !clk_prev_reg[2];
    c_rise        = pin.c && !clk_prev_reg[1];
    cn_rise       = pin.c_n && !clk_prev_reg[0];
    out_rise      = pin.single_clk ? k_rise : c_rise;
    out_fall      = pin.single_clk ? kn_rise : cn_rise;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      clk_prev_reg <= dsb_pkg::RST_CLKS;
    end else begin
      clk_prev_reg <= clk_prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command capture and write data capture

  logic [1:0]                  wr_phase_reg, wr_phase_next;
  logic [dsb_pkg::ADDR_W-1:0]  wr_addr_reg, wr_addr_next;
  logic                        rd_pend_reg, rd_pend_next;
  logic [dsb_pkg::ADDR_W-1:0]  rd_addr_reg, rd_addr_next;
  logic                        push_valid, take_read;
  logic                        cmd_load;

  function automatic logic [dsb_pkg::ADDR_W-1:0] second_addr(
    input logic [dsb_pkg::ADDR_W-1:0] a
  );
    second_addr = a ^ dsb_pkg::ADDR_W'(1 << dsb_pkg::BURST_LSB_POS);
  endfunction : second_addr

  always_comb begin
    wr_phase_next = wr_phase_reg;
    wr_addr_next  = wr_addr_reg;
    rd_pend_next  = rd_pend_reg && !take_read;
    rd_addr_next  = rd_addr_reg;
    push_valid    = 1'b0;
    push_word     = '{addr: wr_addr_reg, data: pin.dq, mask_n: pin.byte_lane_mask_n};
    cmd_load      = k_rise && !pin.cycle_define_n;
    if (wr_phase_reg == 2'h1 && kn_rise) begin
      push_valid    = 1'b1;
      wr_phase_next = 2'h2;
    end
    if (wr_phase_reg == 2'h2 && k_rise) begin
      push_valid     = 1'b1;
      push_word.addr = second_addr(wr_addr_reg);
      wr_phase_next  = 2'h0;
    end
    if (cmd_load && !pin.rw && wr_phase_next == 2'h0) begin
      wr_phase_next = 2'h1;
      wr_addr_next  = pin.addr;
    end
    if (cmd_load && pin.rw && !rd_pend_next) begin
      rd_pend_next = 1'b1;
      rd_addr_next = pin.addr;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      wr_phase_reg <= dsb_pkg::RST_PHASE;
      wr_addr_reg  <= dsb_pkg::RST_ADDR;
      rd_pend_reg  <= 1'b0;
      rd_addr_reg  <= dsb_pkg::RST_ADDR;
    end else begin
      wr_phase_reg <= wr_phase_next;
      wr_addr_reg  <= wr_addr_next;
      rd_pend_reg  <= rd_pend_next;
      rd_addr_reg  <= rd_addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write buffer and storage arrays

  logic                       drain_valid, drain_ready, drain_fire;
  logic [dsb_pkg::LANES-1:0]  lane_wr;
  logic [dsb_pkg::DATA_W-1:0] rd_word;
  logic [dsb_pkg::ADDR_W-1:0] fetch_addr;
  dsb_state_type              state_reg, state_next;

  dsb_fifo #(
    .W     ($bits(dsb_pkg::dsb_wr_word_type)),
    .DEPTH (dsb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_REF_CLK),
    .i_rst_n     (I_RST_N),
    .i_in_valid  (push_valid),
    .o_in_ready  (O_WRITE_READY),
    .i_in_data   (push_word),
    .o_out_valid (drain_valid),
    .i_out_ready (drain_ready),
    .o_out_data  (drain_word)
  );

  // array port belongs to read fetch first
  always_comb begin
    drain_ready = (state_reg != ST_FETCH0) && (state_reg != ST_FETCH1);
    drain_fire  = drain_valid && drain_ready;
    fetch_addr  = (state_reg == ST_FETCH1) ? second_addr(rd_addr_reg) : rd_addr_reg;
  end

  // two banks split by burst lsb
  for (genvar g = 0; g < dsb_pkg::LANES; g++) begin : g_lane
    logic [dsb_pkg::LANE_W-1:0] mem [dsb_pkg::BANKS][dsb_pkg::ROWS];

    assign lane_wr[g] = drain_fire && !drain_word.mask_n[g];

    always_ff @(posedge I_REF_CLK) begin
      if (lane_wr[g]) begin
        mem[drain_word.addr[0]][drain_word.addr[dsb_pkg::ADDR_W-1:1]] <=
          drain_word.data[g*dsb_pkg::LANE_W +: dsb_pkg::LANE_W];
      end
    end

    assign rd_word[g*dsb_pkg::LANE_W +: dsb_pkg::LANE_W] =
      mem[fetch_addr[0]][fetch_addr[dsb_pkg::ADDR_W-1:1]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read sequencer and output drivers

  logic [dsb_pkg::DATA_W-1:0] word0_reg, word0_next;
  logic [dsb_pkg::DATA_W-1:0] word1_reg, word1_next;
  logic [dsb_pkg::DATA_W-1:0] dq_reg, dq_next;
  logic                       oe_n_reg, oe_n_next;

  always_comb begin
    state_next = state_reg;
    word0_next = word0_reg;
    word1_next = word1_reg;
    dq_next    = dq_reg;
    oe_n_next  = oe_n_reg;
    take_read  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        oe_n_next = 1'b1;
        if (rd_pend_reg) begin
          take_read  = 1'b1;
          state_next = ST_FETCH0;
        end
      end
      ST_FETCH0: begin
        word0_next = rd_word;
        state_next = ST_FETCH1;
      end
      ST_FETCH1: begin
        word1_next = rd_word;
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (out_rise) begin
          dq_next    = word0_reg;
          oe_n_next  = 1'b0;
          state_next = ST_DRIVE0;
        end
      end
      ST_DRIVE0: begin
        if (out_fall) begin
          dq_next    = word1_reg;
          state_next = ST_DRIVE1;
        end
      end
      ST_DRIVE1: begin
        if (out_rise) begin
          oe_n_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        oe_n_next  = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      state_reg <= ST_IDLE;
      word0_reg <= dsb_pkg::RST_DQ;
      word1_reg <= dsb_pkg::RST_DQ;
      dq_reg    <= dsb_pkg::RST_DQ;
      oe_n_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      word0_reg <= word0_next;
      word1_reg <= word1_next;
      dq_reg    <= dq_next;
      oe_n_reg  <= oe_n_next;
    end
  end

  assign O_DQ      = dq_reg;
  assign O_DQ_OE_N = oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_out_rise_in_wait;
    state_reg == ST_WAIT && out_rise;
  endsequence

  sequence s_word0_on_pins;
    !O_DQ_OE_N && O_DQ == $past(word0_reg);
  endsequence

  AST_IDLE_RELEASED: assert property (
    state_reg == ST_IDLE |=> O_DQ_OE_N
  ) else $error("data drivers active while idle");

  AST_DRIVE_ON_OUT_RISE: assert property (
    s_out_rise_in_wait |=> s_word0_on_pins
  ) else $error("first read word not driven on output rise");

  AST_SECOND_WORD: assert property (
    state_reg == ST_DRIVE0 && out_fall |=> !O_DQ_OE_N && O_DQ == $past(word1_reg)
  ) else $error("second read word not driven on falling pair");

  AST_OE_ONLY_FROM_EDGE: assert property (
    $fell(O_DQ_OE_N) |-> $past(out_rise)
  ) else $error("drivers enabled without an output clock rise");

  AST_READ_LOAD: assert property (
    $rose(rd_pend_reg) |-> $past(k_rise && !pin.cycle_define_n && pin.rw)
  ) else $error("read taken without a read command");

  AST_WRITE_LOAD: assert property (
    k_rise && !pin.cycle_define_n && !pin.rw && wr_phase_reg == 2'h0
      |=> wr_phase_reg == 2'h1 && wr_addr_reg == $past(pin.addr)
  ) else $error("write command not loaded");

  AST_FIRST_WORD: assert property (
    wr_phase_reg == 2'h1 && kn_rise |-> push_valid && push_word.addr == wr_addr_reg
      && push_word.mask_n == pin.byte_lane_mask_n
  ) else $error("first write word not captured");

  AST_BURST_FLIP: assert property (
    wr_phase_reg == 2'h2 && k_rise |-> push_valid
      && push_word.addr == (wr_addr_reg ^ dsb_pkg::ADDR_W'(1)) ##1 wr_phase_reg != 2'h2
  ) else $error("second write word not at flipped address");

  AST_MASK_KEEPS: assert property (
    drain_fire |-> (lane_wr & drain_word.mask_n) == '0 && (lane_wr | drain_word.mask_n) == '1
  ) else $error("lane written against its mask");

  AST_FETCH_OWNS_ARRAY: assert property (
    state_reg == ST_FETCH0 |-> !drain_fire ##1 state_reg == ST_FETCH1 && !drain_fire
  ) else $error("array written during read fetch");

endmodule : dsb_port

// File: rtl/dsb_sync.sv
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: each bit is a level from outside the reference clock domain
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
module dsb_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // two stages, synchronous reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule : dsb_sync

// File: test/dsb_ctl_model.sv
// Purpose: behavioural memory controller driving the port's pins
// Assumes: link clock of 65 ns made as 6/7 reference cycles per half
// Notes:   clocks stand still between frames, released lines invert
`timescale 1ns/1ps
module dsb_ctl_model (
  input  wire logic                        i_clk,
  input  wire logic [dsb_pkg::DATA_W-1:0]  i_dq,
  input  wire logic                        i_dq_oe_n,
  output logic                             o_k,
  output logic                             o_k_n,
  output logic                             o_c,
  output logic                             o_c_n,
  output logic                             o_single_clk,
  output logic                             o_cycle_define_n,
  output logic                             o_rw,
  output logic [dsb_pkg::LANES-1:0]        o_byte_lane_mask_n,
  output logic [dsb_pkg::ADDR_W-1:0]       o_addr,
  output logic [dsb_pkg::DATA_W-1:0]       o_dq
);
  initial begin
    {o_k, o_c, o_single_clk, o_rw} = 4'h0;
    {o_k_n, o_c_n, o_cycle_define_n} = 3'h7;
    o_byte_lane_mask_n = 2'h3;
    o_addr = 21'h000000;
    o_dq = 18'h00000;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  task automatic set_k(input logic v);
    o_k <= v;
    o_k_n <= !v;
  endtask : set_k

  // output clock pair, or input pair in single mode
  task automatic set_out(input logic v);
    if (o_single_clk) begin
      set_k(v);
    end else begin
      o_c <= v;
      o_c_n <= !v;
    end
  endtask : set_out

  task automatic set_single(input logic v);
    o_single_clk <= v;
    tick(4);
  endtask : set_single

  // load cycle, address and direction together
  task automatic command(input logic [20:0] a, input logic rd);
    o_cycle_define_n <= 1'b0;
    o_rw <= rd;
    o_addr <= a;
    tick(3);
    set_k(1'b1);
    tick(3);
    o_cycle_define_n <= 1'b1;
    o_addr <= ~a;
  endtask : command

  // two words, each with its own masks
  task automatic write_burst(input logic [20:0] a, input logic [17:0] d0, d1,
                             input logic [1:0] m0, m1);
    command(a, 1'b0);
    o_dq <= d0;
    o_byte_lane_mask_n <= m0;
    tick(3);
    set_k(1'b0);
    tick(3);
    o_dq <= d1;
    o_byte_lane_mask_n <= m1;
    tick(4);
    set_k(1'b1);
    tick(3);
    o_dq <= ~d1;
    o_byte_lane_mask_n <= ~m1;
    tick(3);
    set_k(1'b0);
    tick(3);
  endtask : write_burst

  task automatic read_burst(input logic [20:0] a, output logic [17:0] q0, q1,
                            output logic oe0, oe1, rel);
    o_dq <= ~o_dq;
    command(a, 1'b1);
    tick(3);
    set_k(1'b0);
    tick(7);
    set_out(1'b1);
    tick(5);
    #1 q0 = i_dq;
    oe0 = i_dq_oe_n;
    tick(1);
    set_out(1'b0);
    tick(6);
    #1 q1 = i_dq;
    oe1 = i_dq_oe_n;
    tick(1);
    set_out(1'b1);
    tick(5);
    #1 rel = i_dq_oe_n;
    tick(1);
    set_out(1'b0);
    tick(6);
  endtask : read_burst
endmodule : dsb_ctl_model

// File: test/tb_top.sv
// Purpose: self-checking bench for the burst-2 ddr sram port
// Assumes: controller model paces the link, reference clock 200 MHz
// Notes:   write buffer exercised through the port by bursts back to back
`timescale 1ns/1ps
module tb_top;
  logic                      ref_clk;
  logic                      rst_n;
  logic                      k, k_n, c, c_n, single, cdn_n, rw;
  logic [1:0]                mask_n;
  logic [20:0]               addr;
  logic [17:0]               dq_in, dq_out;
  logic                      oe_n, wr_ready;
  logic [17:0]               mem [logic [20:0]];
  int                        n_errors = 0;
  int                        compares = 0;

  dsb_port dut (.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_K(k), .I_K_N(k_n), .I_C(c),
    .I_C_N(c_n), .I_SINGLE_CLK(single), .I_CYCLE_DEFINE_N(cdn_n), .I_RW(rw),
    .I_BYTE_LANE_MASK_N(mask_n), .I_ADDR(addr), .I_DQ(dq_in), .O_DQ(dq_out),
    .O_DQ_OE_N(oe_n), .O_WRITE_READY(wr_ready));
  dsb_ctl_model ctl (.i_clk(ref_clk), .i_dq(dq_out), .i_dq_oe_n(oe_n), .o_k(k),
    .o_k_n(k_n), .o_c(c), .o_c_n(c_n), .o_single_clk(single), .o_cycle_define_n(cdn_n),
    .o_rw(rw), .o_byte_lane_mask_n(mask_n), .o_addr(addr), .o_dq(dq_in));

  // reference clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [17:0] merge(input logic [17:0] o, d, input logic [1:0] m);
    merge = o;
    if (!m[0]) merge[8:0] = d[8:0];
    if (!m[1]) merge[17:9] = d[17:9];
  endfunction : merge

  // write burst and update of the expected array
  task automatic wr(input logic [20:0] a, input logic [17:0] d0, d1,
                    input logic [1:0] m0, m1);
    ctl.write_burst(a, d0, d1, m0, m1);
    mem[a] = merge(mem.exists(a) ? mem[a] : 18'hx, d0, m0);
    mem[a ^ 21'h1] = merge(mem.exists(a ^ 21'h1) ? mem[a ^ 21'h1] : 18'hx, d1, m1);
    ctl.tick(10);
  endtask : wr

  task automatic rd(input logic [20:0] a);
    logic [17:0] q0, q1;
    logic        oe0, oe1, rel;
    ctl.read_burst(a, q0, q1, oe0, oe1, rel);
    check(q0, mem[a]);
    check(q1, mem[a ^ 21'h1]);
    check(oe0, 1'b0);
    check(oe1, 1'b0);
    check(rel, 1'b1);
    // ready settles after the edge, then realign to the clock
    #1 check(wr_ready, 1'b1);
    @(posedge ref_clk);
  endtask : rd

  task automatic t_even();
    wr(21'h000010, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
    wr(21'h000020, 18'h3C3C3, 18'h03C3C, 2'h0, 2'h0);
    rd(21'h000010);
    rd(21'h000020);
  endtask : t_even

  // odd start wraps inside the aligned pair
  task automatic t_odd();
    wr(21'h000033, 18'h11111, 18'h22222, 2'h0, 2'h0);
    rd(21'h000033);
    rd(21'h000032);
  endtask : t_odd

  task automatic t_masks();
    wr(21'h000010, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h1);
    wr(21'h000020, 18'h00000, 18'h00000, 2'h3, 2'h3);
    rd(21'h000010);
    rd(21'h000020);
  endtask : t_masks

  // top address bit selects distinct words
  task automatic t_top();
    wr(21'h1FFFFE, 18'h0ABCD, 18'h1BCDE, 2'h0, 2'h0);
    wr(21'h0FFFFE, 18'h2CDEF, 18'h3DEF0, 2'h0, 2'h0);
    rd(21'h1FFFFE);
    rd(21'h0FFFFE);
  endtask : t_top

  // single clock mode paces reads on the input pair
  task automatic t_single();
    ctl.set_single(1'b1);
    rd(21'h000033);
    rd(21'h1FFFFF);
    ctl.set_single(1'b0);
  endtask : t_single

  // write buffer keeps up: two bursts back to back, read back at once
  task automatic t_fifo();
    logic [17:0] q0, q1;
    logic        oe0, oe1, rel;
    ctl.write_burst(21'h000040, 18'h12345, 18'h23456, 2'h0, 2'h0);
    ctl.write_burst(21'h000042, 18'h34567, 18'h05678, 2'h0, 2'h0);
    #1 check(wr_ready, 1'b1);
    @(posedge ref_clk);
    ctl.read_burst(21'h000041, q0, q1, oe0, oe1, rel);
    check(q0, 18'h23456);
    check(q1, 18'h12345);
    ctl.read_burst(21'h000042, q0, q1, oe0, oe1, rel);
    check(q0, 18'h34567);
    check(q1, 18'h05678);
  endtask : t_fifo

  // watchdog
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    repeat (15) @(posedge ref_clk);
    #1 check(oe_n, 1'b1);
    check(dq_out, 18'h00000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_even();
    t_odd();
    t_masks();
    t_top();
    t_single();
    t_fifo();
    print_verdict();
  end
endmodule : tb_top
